/* File: shared/dtm_pkg.sv */
// constants and carrier types shared by the dual timer block
package dtm_pkg;
    // module configuration values
    localparam logic [2:0] CFG_32_TIMER = 3'h0;
    localparam logic [2:0] CFG_32_RTC   = 3'h1;
    localparam logic [2:0] CFG_16       = 3'h4;
    // half mode field encodings
    localparam logic [1:0] MODE_ONESHOT  = 2'h1;
    localparam logic [1:0] MODE_PERIODIC = 2'h2;
    localparam logic [1:0] MODE_CAPTURE  = 2'h3;
    // edge select encodings
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;
    // values after reset
    localparam logic [15:0] CNT_RST = 16'hFFFF;
    localparam logic [15:0] ILR_RST = 16'hFFFF;
    localparam logic [7:0]  PR_RST  = 8'h00;
    // real-time-clock load and roll values
    localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
    localparam logic [31:0] RTC_ROLL  = 32'h0000_0000;
    // real-time-clock input and tick rates
    localparam int unsigned RTC_IN_HZ   = 32768;
    localparam int unsigned RTC_TICK_HZ = 1;
    localparam int unsigned RTC_DIV     = RTC_IN_HZ / RTC_TICK_HZ;

    // per-half mode register
    typedef struct packed {
        logic       cap_mode; // 0 edge count, 1 edge time
        logic [1:0] mode;     // one-shot, periodic, capture
    } dtm_mode_t;

    // per-half control bits
    typedef struct packed {
        logic       en_set;   // pulse: set enable
        logic       en_clr;   // pulse: clear enable
        logic       trig_en;  // converter trigger enable
        logic       stall;    // freeze on debug halt, except in edge count
        logic [1:0] evt;      // edge select
    } dtm_ctl_t;

    // per-half flag group (mask or clear)
    typedef struct packed {
        logic to; // time-out
        logic cm; // edge-count match
    } dtm_flag_t;
endpackage

/* File: hdl/dtm_sync_edge.sv */
// two-flop synchroniser with edge detect for each input pin
`timescale 1ns/1ps
`default_nettype none
module dtm_sync_edge #(
    parameter int W = 2
) (
    input  wire logic         sys_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            logic meta; // first stage, read only by sync
            logic sync; // second stage
            logic prev; // last sampled level
            // sample chain
            always_ff @(posedge sys_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                    prev <= 1'b0;
                end else begin
                    meta <= pin_i[g];
                    sync <= meta;
                    prev <= sync;
                end
            end
            // one pulse per edge
            assign rise_o[g] = sync & ~prev; // [R25]
            assign fall_o[g] = ~sync & prev; // [R25]
        end
    endgenerate
endmodule
`default_nettype wire

/* File: hdl/dtm_top.sv */
// dual 16-bit timer, joined 32-bit timer / rtc, edge counter
// Contract
// R1: config 0 or 1 joins halves
// R2: 32-bit load write fills both halves
// R3: first count reads both halves joined
// R4: joined down-counter uses first mode field only
// R5: zero reloads next cycle; one-shot clears enable
// R6: zero sets sticky time-out flag, masked copy
// R7: trigger only while trigger enable set
// R8: load rewrite takes effect next cycle
// R9: stall bit freezes counter during halt; the edge-count halves keep counting
// R10: rtc counts up, first load one
// R11: even capture pin divided to 1 Hz
// R12: rtc match rolls to zero, sets flag
// R13: rtc enable overrides debug stall
// R14: config 4 splits two independent halves
// R15: 16-bit down-counter with 8-bit prescaler
// R16: half zero reloads interval and prescale
// R17: half time-out flags and own trigger
// R18: edge count bypasses the prescaler
// R19: capture bit 0 selects edge count
// R20: each edge decrements; match sets flag
// R21: match reloads, clears enable, ignores edges
// R22: software sets load minus match edges
// R23: capture input held two clocks per edge
// R24: reset counters, loads 0xFFFF, prescale zero
// R25: inputs synchronised, each edge acted once
`timescale 1ns/1ps
`default_nettype none
module dtm_top #(
    parameter int unsigned RTC_DIV = dtm_pkg::RTC_DIV
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    nrst_i,
    input  wire logic [2:0]              module_config_reg_i,
    input  wire logic [1:0]              ilr_wr_i,
    input  wire logic [31:0]             ilr_data_i,
    input  wire logic [1:0]              pr_wr_i,
    input  wire logic [7:0]              pr_data_i,
    input  wire logic [31:0]             first_match_reg_i,
    input  wire logic [15:0]             second_match_reg_i,
    input  wire dtm_pkg::dtm_mode_t [1:0] half_mode_reg_i,
    input  wire dtm_pkg::dtm_ctl_t [1:0]  half_ctl_i,
    input  wire logic                    clock_run_enable_i,
    input  wire logic                    halt_i,
    input  wire dtm_pkg::dtm_flag_t [1:0] flag_mask_reg_i,
    input  wire dtm_pkg::dtm_flag_t [1:0] flag_clear_reg_i,
    input  wire logic                    clock_mask_i,
    input  wire logic                    clock_match_clear_i,
    input  wire logic [1:0]              capture_pin_i,
    output logic      [31:0]             first_count_value_o,
    output logic      [15:0]             second_count_value_o,
    output logic      [1:0]              half_enable_bit_o,
    output logic      [1:0]              half_timeout_raw_o,
    output logic      [1:0]              half_timeout_masked_o,
    output logic      [1:0]              edge_match_raw_o,
    output logic      [1:0]              edge_match_masked_o,
    output logic                         clock_match_raw_o,
    output logic                         clock_match_masked_o,
    output logic                         irq_o,
    output logic                         adc_trigger_o
);
    logic [15:0] cnt [2];       // half counters
    logic [15:0] next_cnt [2];  // counter next values
    logic [15:0] ilr [2];       // interval load registers
    logic [7:0]  pr [2];        // prescale reload values
    logic [7:0]  ps [2];        // running prescale counters
    logic [7:0]  next_ps [2];   // prescale next values
    logic [1:0]  en;            // half enable bits
    logic [1:0]  next_en;       // enable next values
    logic [1:0]  hw_clr;        // enable cleared by hardware
    logic [1:0]  to_ev;         // time-out events
    logic [1:0]  cm_ev;         // edge match events
    logic        rtc_ev;        // rtc match event
    logic        rtc_seen;      // rtc mode selected before
    logic        next_seen;     // rtc_seen next value
    logic [15:0] div;           // rtc input divider
    logic        rtc_tick;      // 1 Hz advance pulse
    logic [1:0]  pin_rise;      // synced rising edges
    logic [1:0]  pin_fall;      // synced falling edges
    logic [15:0] match16 [2];   // per-half match values
    logic [31:0] cnt32;         // joined count
    logic [31:0] ilr32;         // joined load value
    logic        m32;           // joined one-shot/periodic
    logic        mrtc;          // joined rtc
    logic        m16;           // split halves
    logic        run32;         // joined timer advancing
    logic        run_rtc;       // rtc advancing
    logic [1:0]  run;           // half advancing
    logic [1:0]  next_to_raw;   // time-out raw next
    logic [1:0]  next_cm_raw;   // edge match raw next
    logic        next_rtc_raw;  // rtc raw next
    logic [1:0]  next_to_mis;   // time-out masked next
    logic [1:0]  next_cm_mis;   // edge match masked next
    logic        next_rtc_mis;  // rtc masked next

    // selected edge test, shared by both halves
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic r,
                                      input logic f);
        case (sel)
            dtm_pkg::EVT_RISE: edge_hit = r;
            dtm_pkg::EVT_FALL: edge_hit = f;
            dtm_pkg::EVT_BOTH: edge_hit = r | f;
            default:           edge_hit = 1'b0;
        endcase
    endfunction

    // capture pins into the clock domain
    dtm_sync_edge #(
        .W(2)
    ) i_dtm_sync_edge (
        .sys_clk_i(sys_clk_i),
        .nrst_i   (nrst_i),
        .pin_i    (capture_pin_i),
        .rise_o   (pin_rise),
        .fall_o   (pin_fall)
    );

    // mode decode
    assign m32   = module_config_reg_i == dtm_pkg::CFG_32_TIMER; // [R1]
    assign mrtc  = module_config_reg_i == dtm_pkg::CFG_32_RTC;   // [R1]
    assign m16   = module_config_reg_i == dtm_pkg::CFG_16;       // [R14]
    assign cnt32 = {cnt[1], cnt[0]};
    assign ilr32 = {ilr[1], ilr[0]};
    assign match16[0] = first_match_reg_i[15:0];
    assign match16[1] = second_match_reg_i;

    // advance qualifiers with debug stall
    assign run32   = en[0] & ~(half_ctl_i[0].stall & halt_i); // [R9]
    assign run[0]  = en[0] & ~(half_ctl_i[0].stall & halt_i); // [R9]
    assign run[1]  = en[1] & ~(half_ctl_i[1].stall & halt_i); // [R9]
    assign run_rtc = en[0] & (clock_run_enable_i | ~halt_i  // [R13]
                   | ~(half_ctl_i[0].stall | half_ctl_i[1].stall));

    // rtc divider on even capture input edges
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div <= 16'h0000;
        end else if (!mrtc || !en[0]) begin
            div <= 16'h0000;
        end else if (pin_rise[0] && run_rtc) begin
            if (rtc_tick) begin
                div <= 16'h0000; // [R11]
            end else begin
                div <= div + 16'h0001;
            end
        end
    end
    assign rtc_tick = pin_rise[0] && (div == 16'(RTC_DIV - 1)); // [R11]

    // counter next-state for every mode
    always_comb begin
        next_cnt  = cnt;
        next_ps   = ps;
        hw_clr    = 2'b00;
        to_ev     = 2'b00;
        cm_ev     = 2'b00;
        rtc_ev    = 1'b0;
        next_seen = rtc_seen;
        if (m32) begin
            // joined down-counter
            if (run32) begin
                if (cnt32 == 32'h0000_0000) begin
                    {next_cnt[1], next_cnt[0]} = ilr32; // [R5]
                    to_ev[0] = 1'b1;                    // [R6]
                    if (half_mode_reg_i[0].mode == dtm_pkg::MODE_ONESHOT) begin
                        hw_clr[0] = 1'b1;               // [R4] [R5]
                    end
                end else begin
                    {next_cnt[1], next_cnt[0]} = cnt32 - 32'h0000_0001; // [R4]
                end
            end
        end else if (mrtc) begin
            // joined up-counter
            if (!rtc_seen) begin
                {next_cnt[1], next_cnt[0]} = dtm_pkg::RTC_FIRST; // [R10]
                next_seen = 1'b1;
            end else if (rtc_tick && run_rtc) begin
                if (cnt32 == first_match_reg_i) begin
                    {next_cnt[1], next_cnt[0]} = dtm_pkg::RTC_ROLL; // [R12]
                    rtc_ev = 1'b1;                                  // [R12]
                end else begin
                    {next_cnt[1], next_cnt[0]} = cnt32 + 32'h0000_0001; // [R10]
                end
            end
        end else if (m16) begin
            // two independent halves
            for (int h = 0; h < 2; h++) begin
                if (half_mode_reg_i[h].mode == dtm_pkg::MODE_CAPTURE) begin
                    // edge count, no prescaler
                    if (!half_mode_reg_i[h].cap_mode && en[h]        // [R19] [R21]
                        && edge_hit(half_ctl_i[h].evt, pin_rise[h], pin_fall[h])) begin
                        if (cnt[h] - 16'h0001 == match16[h]) begin
                            next_cnt[h] = ilr[h]; // [R21]
                            cm_ev[h]    = 1'b1;   // [R20]
                            hw_clr[h]   = 1'b1;   // [R21]
                        end else begin
                            next_cnt[h] = cnt[h] - 16'h0001; // [R18] [R20]
                        end
                    end
                end else if (run[h] && half_mode_reg_i[h].mode != 2'h0) begin
                    // prescaled down-counter
                    if (ps[h] != 8'h00) begin
                        next_ps[h] = ps[h] - 8'h01; // [R15]
                    end else if (cnt[h] == 16'h0000) begin
                        next_cnt[h] = ilr[h]; // [R16]
                        next_ps[h]  = pr[h];  // [R16]
                        to_ev[h]    = 1'b1;   // [R17]
                        if (half_mode_reg_i[h].mode == dtm_pkg::MODE_ONESHOT) begin
                            hw_clr[h] = 1'b1; // [R16]
                        end
                    end else begin
                        next_cnt[h] = cnt[h] - 16'h0001; // [R15]
                        next_ps[h]  = pr[h];
                    end
                end
            end
        end
        // load rewrite wins over counting
        if (ilr_wr_i[0] && m32) begin
            {next_cnt[1], next_cnt[0]} = ilr_data_i; // [R2] [R8]
        end else if (ilr_wr_i[0] && m16) begin
            next_cnt[0] = ilr_data_i[15:0];          // [R8]
        end
        if (ilr_wr_i[1] && m16) begin
            next_cnt[1] = ilr_data_i[15:0];          // [R8]
        end
    end

    // counters and prescalers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt      <= '{dtm_pkg::CNT_RST, dtm_pkg::CNT_RST}; // [R24]
            ps       <= '{dtm_pkg::PR_RST, dtm_pkg::PR_RST};   // [R24]
            rtc_seen <= 1'b0;
        end else begin
            cnt      <= next_cnt;
            ps       <= next_ps;
            rtc_seen <= next_seen;
        end
    end

    // interval load and prescale registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ilr <= '{dtm_pkg::ILR_RST, dtm_pkg::ILR_RST}; // [R24]
            pr  <= '{dtm_pkg::PR_RST, dtm_pkg::PR_RST};   // [R24]
        end else begin
            if (ilr_wr_i[0] && (m32 || mrtc)) begin
                ilr[1] <= ilr_data_i[31:16]; // [R2]
                ilr[0] <= ilr_data_i[15:0];  // [R2]
            end else begin
                if (ilr_wr_i[0]) begin
                    ilr[0] <= ilr_data_i[15:0];
                end
                if (ilr_wr_i[1]) begin
                    ilr[1] <= ilr_data_i[15:0];
                end
            end
            for (int h = 0; h < 2; h++) begin
                if (pr_wr_i[h]) begin
                    pr[h] <= pr_data_i;
                end
            end
        end
    end

    // enable bits: software set beats hardware clear
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            if (half_ctl_i[h].en_set) begin
                next_en[h] = 1'b1;
            end else if (half_ctl_i[h].en_clr || hw_clr[h]) begin
                next_en[h] = 1'b0; // [R5] [R16] [R21]
            end else begin
                next_en[h] = en[h];
            end
        end
    end

    // sticky flags: hardware set beats clear
    always_comb begin
        for (int h = 0; h < 2; h++) begin
            next_to_raw[h] = (half_timeout_raw_o[h] & ~flag_clear_reg_i[h].to)
                           | to_ev[h]; // [R6] [R17]
            next_cm_raw[h] = (edge_match_raw_o[h] & ~flag_clear_reg_i[h].cm)
                           | cm_ev[h]; // [R20]
            next_to_mis[h] = next_to_raw[h] & flag_mask_reg_i[h].to;
            next_cm_mis[h] = next_cm_raw[h] & flag_mask_reg_i[h].cm;
        end
        next_rtc_raw = (clock_match_raw_o & ~clock_match_clear_i) | rtc_ev; // [R12]
        next_rtc_mis = next_rtc_raw & clock_mask_i;                         // [R12]
    end

    // enable state and flag outputs
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en                    <= 2'b00; // [R24]
            half_enable_bit_o     <= 2'b00;
            half_timeout_raw_o    <= 2'b00;
            half_timeout_masked_o <= 2'b00;
            edge_match_raw_o      <= 2'b00;
            edge_match_masked_o   <= 2'b00;
            clock_match_raw_o     <= 1'b0;
            clock_match_masked_o  <= 1'b0;
            irq_o                 <= 1'b0;
        end else begin
            en                    <= next_en;
            half_enable_bit_o     <= next_en;
            half_timeout_raw_o    <= next_to_raw;
            half_timeout_masked_o <= next_to_mis; // [R6] [R17]
            edge_match_raw_o      <= next_cm_raw;
            edge_match_masked_o   <= next_cm_mis; // [R20]
            clock_match_raw_o     <= next_rtc_raw;
            clock_match_masked_o  <= next_rtc_mis;
            irq_o                 <= |{next_to_mis, next_cm_mis, next_rtc_mis};
        end
    end

    // count views and converter trigger
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            first_count_value_o  <= {dtm_pkg::CNT_RST, dtm_pkg::CNT_RST};
            second_count_value_o <= dtm_pkg::CNT_RST;
            adc_trigger_o        <= 1'b0;
        end else begin
            if (m16) begin
                first_count_value_o <= {16'h0000, next_cnt[0]};
            end else begin
                first_count_value_o <= {next_cnt[1], next_cnt[0]}; // [R3]
            end
            second_count_value_o <= next_cnt[1];
            adc_trigger_o <= |(to_ev & {half_ctl_i[1].trig_en,
                                        half_ctl_i[0].trig_en}); // [R7] [R17]
        end
    end

    oneshot_stop_a: // [R5]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            m32 && run32 && cnt32 == 32'h0000_0000 && !ilr_wr_i[0]
            && !half_ctl_i[0].en_set
            && half_mode_reg_i[0].mode == dtm_pkg::MODE_ONESHOT
            |=> !half_enable_bit_o[0] && cnt32 == $past(ilr32))
        else $error("one-shot did not reload and stop");
    periodic_keep_a: // [R5]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            m32 && run32 && cnt32 == 32'h0000_0000 && !half_ctl_i[0].en_clr
            && half_mode_reg_i[0].mode == dtm_pkg::MODE_PERIODIC
            |=> half_enable_bit_o[0] && half_timeout_raw_o[0])
        else $error("periodic timer stopped at time-out");
    timeout_hold_a: // [R6]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            half_timeout_raw_o[0] && !flag_clear_reg_i[0].to
            |=> half_timeout_raw_o[0])
        else $error("time-out flag dropped without clear");
    trig_gate_a: // [R7]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            adc_trigger_o |-> $past(half_ctl_i[0].trig_en & to_ev[0])
            || $past(half_ctl_i[1].trig_en & to_ev[1]))
        else $error("trigger without enabled time-out");
    load_take_a: // [R8]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            ilr_wr_i[0] && m32 |=> first_count_value_o == $past(ilr_data_i))
        else $error("load rewrite not taken next cycle");
    stall_hold_a: // [R9]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            m32 && half_ctl_i[0].stall && halt_i && !ilr_wr_i[0]
            |=> cnt32 == $past(cnt32))
        else $error("counter moved during debug stall");
    rtc_roll_a: // [R12]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            mrtc && rtc_seen && rtc_tick && run_rtc
            && cnt32 == first_match_reg_i
            |=> cnt32 == 32'h0000_0000 && clock_match_raw_o)
        else $error("rtc match did not roll and flag");
    edge_stop_a: // [R21]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            cm_ev[0] && !half_ctl_i[0].en_set && !ilr_wr_i[0]
            |=> !half_enable_bit_o[0] && edge_match_raw_o[0]
            && cnt[0] == $past(ilr[0]))
        else $error("edge match did not reload and stop");
    edge_bypass_a: // [R18]
        assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
            m16 && half_mode_reg_i[0].mode == dtm_pkg::MODE_CAPTURE
            && !pin_rise[0] && !pin_fall[0] && !ilr_wr_i[0]
            |=> cnt[0] == $past(cnt[0]))
        else $error("edge counter moved without edge");
endmodule
`default_nettype wire

/* File: tb/dtm_top_test.sv */
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtm_top_test;
    logic                      sys_clk_i = 1'b0;  // 10 MHz system clock
    logic                      nrst_i    = 1'b0;  // reset, active low
    logic [2:0]                cfg       = 3'h0;  // module configuration
    logic [1:0]                ilr_wr    = 2'h0;  // interval load pulses
    logic [31:0]               ilr_data  = 32'h0000_0000;
    logic [1:0]                pr_wr     = 2'h0;  // prescale write pulses
    logic [7:0]                pr_data   = 8'h00;
    logic [31:0]               match0    = 32'h0000_0000;
    dtm_pkg::dtm_mode_t [1:0]  mode      = '0;    // per-half modes
    dtm_pkg::dtm_ctl_t [1:0]   ctl       = '0;    // per-half control
    dtm_pkg::dtm_flag_t [1:0]  mask      = '0;    // flag masks
    dtm_pkg::dtm_flag_t [1:0]  clr       = '0;    // flag clear pulses
    logic                      run_en    = 1'b0;  // rtc ignores stall
    logic                      halt      = 1'b0;  // debugger halt
    logic                      rtc_mask  = 1'b0;
    logic                      rtc_clr   = 1'b0;
    logic [1:0]                pin       = 2'h0;  // capture pins
    logic [31:0]               cnt0;              // joined count view
    logic [15:0]               cnt1;              // second half count
    logic [1:0]                en, to_raw, to_msk, cm_raw, cm_msk;
    logic                      rtc_raw, rtc_msk, irq, trig;
    logic [31:0]               held;              // frozen count
    int                        trig_seen   = 0;   // trigger pulses seen
    int                        mismatches  = 0;
    int                        comparisons = 0;

    // small divider keeps the rtc tick short
    dtm_top #(.RTC_DIV(4)) i_dtm_top (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .module_config_reg_i(cfg),
        .ilr_wr_i(ilr_wr), .ilr_data_i(ilr_data), .pr_wr_i(pr_wr), .pr_data_i(pr_data),
        .first_match_reg_i(match0), .second_match_reg_i(16'h0000),
        .half_mode_reg_i(mode), .half_ctl_i(ctl), .clock_run_enable_i(run_en),
        .halt_i(halt), .flag_mask_reg_i(mask), .flag_clear_reg_i(clr),
        .clock_mask_i(rtc_mask), .clock_match_clear_i(rtc_clr), .capture_pin_i(pin),
        .first_count_value_o(cnt0), .second_count_value_o(cnt1),
        .half_enable_bit_o(en), .half_timeout_raw_o(to_raw),
        .half_timeout_masked_o(to_msk), .edge_match_raw_o(cm_raw),
        .edge_match_masked_o(cm_msk), .clock_match_raw_o(rtc_raw),
        .clock_match_masked_o(rtc_msk), .irq_o(irq), .adc_trigger_o(trig));

    // clock generator
    initial begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    // count converter trigger pulses
    always @(posedge sys_clk_i) begin
        if (trig === 1'b1) trig_seen <= trig_seen + 1;
    end

    // verdict and end of run
    task stop_test;
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // compare any result against its expected value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // wait n falling edges
    task tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask

    // one-cycle pulse: 0 load, 1 enable, 2 disable, 3 clear time-out, 4 rtc clear, 5 prescale
    task pulse(input int h, input int k);
        @(negedge sys_clk_i);
        case (k)
            0: ilr_wr[h] = 1'b1;
            1: ctl[h].en_set = 1'b1;
            2: ctl[h].en_clr = 1'b1;
            3: clr[h].to = 1'b1;
            4: rtc_clr = 1'b1;
            default: pr_wr[h] = 1'b1;
        endcase
        @(negedge sys_clk_i);
        ilr_wr = 2'h0;
        pr_wr = 2'h0;
        clr = '0;
        rtc_clr = 1'b0;
        for (int i = 0; i < 2; i++) begin
            ctl[i].en_set = 1'b0;
            ctl[i].en_clr = 1'b0;
        end
    endtask

    // toggle capture pin 0, four clocks per level
    task toggle(input int k);
        repeat (k) begin
            @(negedge sys_clk_i);
            pin[0] = ~pin[0];
            tick(3);
        end
        tick(2);
    endtask

    // wait for a time-out flag of one half, bounded
    task wait_to(input int h);
        for (int n = 0; n < 200 && to_raw[h] !== 1'b1; n++) tick(1);
        tick(2);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        mismatches++;
        stop_test();
    end

    // test sequence
    initial begin
        tick(3);
        chk(cnt0, 32'hFFFF_FFFF);
        chk({cnt1, 14'h0, en}, {dtm_pkg::CNT_RST, 16'h0000});
        nrst_i = 1'b1;
        cfg = dtm_pkg::CFG_32_RTC;
        tick(2);
        chk(cnt0, dtm_pkg::RTC_FIRST);
        match0 = 32'h0000_0002;
        {rtc_mask, run_en, halt, ctl[0].stall} = 4'hF;
        pulse(0, 1);
        toggle(16);
        chk({cnt0[3:0], rtc_raw, rtc_msk, irq}, 7'h07);
        pulse(0, 4);
        chk({rtc_raw, rtc_msk}, 2'h0);
        pulse(0, 2);
        {rtc_mask, halt, ctl[0].stall} = 3'h0;
        cfg = dtm_pkg::CFG_32_TIMER;
        mode[0] = {1'b0, dtm_pkg::MODE_ONESHOT};
        mode[1] = {1'b0, dtm_pkg::MODE_CAPTURE};
        ctl[0].trig_en = 1'b1;
        mask[0].to = 1'b1;
        ilr_data = 32'h0000_0004;
        pulse(0, 0);
        pulse(0, 1);
        wait_to(0);
        chk(cnt0, 32'h0000_0004);
        chk({en[0], to_msk[0], irq}, 3'h3);
        chk(trig_seen, 1);
        pulse(0, 3);
        chk(to_raw[0], 1'b0);
        ctl[0].trig_en = 1'b0;
        mode[0] = {1'b0, dtm_pkg::MODE_PERIODIC};
        ilr_data = 32'h0003_0001;
        pulse(0, 0);
        chk(cnt0, 32'h0003_0001);
        chk(cnt1, 16'h0003);
        pulse(0, 1);
        ilr_data = 32'h0000_0040;
        pulse(0, 0);
        chk(cnt0, 32'h0000_0040);
        {halt, ctl[0].stall} = 2'h3;
        tick(1);
        held = cnt0;
        tick(5);
        chk(cnt0, held);
        halt = 1'b0;
        tick(3);
        chk(cnt0, held - 32'h3);
        ilr_data = 32'h0000_0002;
        pulse(0, 0);
        wait_to(0);
        chk({en[0], to_raw[0], 30'h0}, {2'h3, 30'h0});
        chk(trig_seen, 1);
        pulse(0, 2);
        pulse(0, 3);
        cfg = dtm_pkg::CFG_16;
        mode[0] = {1'b0, dtm_pkg::MODE_CAPTURE};
        mode[1] = {1'b0, dtm_pkg::MODE_PERIODIC};
        ctl[0].evt = dtm_pkg::EVT_BOTH;
        mask[0].cm = 1'b1;
        match0 = 32'h0000_0006;
        ilr_data = 32'h0000_000A;
        pulse(0, 0);
        ilr_data = 32'h0000_0003;
        pulse(1, 0);
        pr_data = 8'h01;
        pulse(1, 5);
        pulse(0, 1);
        pulse(1, 1);
        toggle(6);
        chk(cnt0, 32'h0000_000A);
        chk({cm_raw[0], cm_msk[0], en[0]}, 3'h6);
        chk({to_raw[1], en[1]}, 2'h3);
        stop_test();
    end
endmodule
`default_nettype wire
